/* File: hw/adcc_pkg.sv */
// constants, types and register map for the converter control block
// Contract
// - wait mode leaves conversion running, done wakes if bit 7
// - done flag cleared only by new start
// - completion sets bit 6, irq if bit 7
// - result valid only while done flag set
// - bit 5 write-only start, reads zero
// - start clears done flag and interrupt
// - restart abandons running conversion
// - bit 4 powers converter on or off
// - bit 2 disables main oscillator only
// - result register at 0d0h, eight bits
// - control at 0d1h, bit6 RO, bit5 WO
// - control reads 40h after reset
// - one conversion per start request
package adcc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   // register numbers; each register owns one aligned word, byte address is four times
   localparam logic [7:0] ADCC_RESULT_IDX = 8'hd0;
   localparam logic [7:0] ADCC_CTRL_IDX = 8'hd1;
   localparam logic [31:0] ADCC_RESULT_ADDR = {22'h0, ADCC_RESULT_IDX, 2'b00};
   localparam logic [31:0] ADCC_CTRL_ADDR = {22'h0, ADCC_CTRL_IDX, 2'b00};
   localparam logic [7:0] ADCC_CTRL_RESET = 8'h40;
   localparam int ADCC_BIT_IE = 7;
   localparam int ADCC_BIT_DONE = 6;
   localparam int ADCC_BIT_START = 5;
   localparam int ADCC_BIT_PWR = 4;
   localparam int ADCC_BIT_OSC = 2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int ADCC_CLK_PER_BIT = 4;
   localparam int ADCC_NBITS = 8;
   // bundle from sequencer to analog comparator
   typedef struct packed {
      logic [7:0] trial;
      logic sample;
   } adcc_dac_s;
   typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV, ADCC_LOAD} adcc_state_e;
endpackage

/* File: hw/adcc_top.sv */
// converter control, status, sequencer and apb slave
`timescale 1ns/1ps
module adcc_top import adcc_pkg::*; (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // power modes
   input wire logic WAIT_MODE,
   input wire logic STOP_MODE,
   // analog side
   input wire logic CMP_HIGH,
   output adcc_dac_s DAC,
   output logic CONV_POWER,
   // system
   output logic IRQ,
   output logic WAKE,
   output logic MAIN_OSC_DISABLE
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic acc, wr, hit_res, hit_ctl, start_wr;
   assign acc = PSEL && PENABLE;
   assign wr = acc && PWRITE;
   assign hit_res = PADDR == ADCC_RESULT_ADDR;
   assign hit_ctl = PADDR == ADCC_CTRL_ADDR;
   assign PREADY = 1'b1;
   // unmapped or written read-only result answers with error
   assign PSLVERR = acc && !(hit_ctl || (hit_res && !PWRITE));
   assign start_wr = wr && hit_ctl && PWDATA[ADCC_BIT_START];

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   logic ie_q, pwr_q, osc_q, done_q;
   logic [7:0] result_q;
   logic [7:0] trial_q;
   logic [2:0] bit_q;
   logic [1:0] tick_q;
   logic sample_q, cmp_s1, cmp_s2, cmp_s3;
   adcc_state_e state_q;

   // writable fields; reserved bits are not stored
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ie_q <= 1'b0;
         pwr_q <= 1'b0;
         osc_q <= 1'b0;
      end else if (wr && hit_ctl) begin
         ie_q <= PWDATA[ADCC_BIT_IE];
         pwr_q <= PWDATA[ADCC_BIT_PWR];
         osc_q <= PWDATA[ADCC_BIT_OSC];
      end
   end

   // converter is live only when powered and not in stop
   logic live;
   assign live = pwr_q && !STOP_MODE;
   logic fin;
   assign fin = state_q == ADCC_LOAD;

   // done flag: start clears, completion sets, writes of zero ignored
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         done_q <= 1'b1;
      end else if (start_wr) begin
         done_q <= 1'b0;
      end else if (fin) begin
         done_q <= 1'b1;
      end
   end

   // comparator crosses from analog domain: three stages
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         cmp_s3 <= 1'b0;
      end else begin
         cmp_s1 <= CMP_HIGH;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
      end
   end
   logic cmp_ok;
   assign cmp_ok = cmp_s2 == cmp_s3;

   // ----------------------------------------
   // successive approximation sequencer
   // ----------------------------------------
   // wait mode is not looked at: conversion continues unchanged
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_q <= ADCC_IDLE;
         trial_q <= 8'h00;
         bit_q <= 3'h0;
         tick_q <= 2'h0;
         sample_q <= 1'b0;
      end else if (start_wr && live) begin
         state_q <= ADCC_CONV;
         trial_q <= 8'h80;
         bit_q <= 3'h7;
         tick_q <= 2'h0;
         sample_q <= 1'b1;
      end else if (!live) begin
         state_q <= ADCC_IDLE;
         sample_q <= 1'b0;
      end else begin
         case (state_q)
            ADCC_IDLE: begin
               sample_q <= 1'b0;
            end
            ADCC_CONV: begin
               // decide only when the comparator has settled
               if (tick_q == 2'(ADCC_CLK_PER_BIT - 1) && cmp_ok) begin
                  tick_q <= 2'h0;
                  if (!cmp_s3) begin
                     trial_q[bit_q] <= 1'b0;
                  end
                  if (bit_q == 3'h0) begin
                     state_q <= ADCC_LOAD;
                  end else begin
                     trial_q[bit_q - 3'h1] <= 1'b1;
                     bit_q <= bit_q - 3'h1;
                  end
               end else if (tick_q != 2'(ADCC_CLK_PER_BIT - 1)) begin
                  tick_q <= tick_q + 2'h1;
               end
            end
            ADCC_LOAD: begin
               state_q <= ADCC_IDLE;
               sample_q <= 1'b0;
            end
            default: state_q <= ADCC_IDLE;
         endcase
      end
   end

   // result loaded one cycle before done is visible
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         result_q <= 8'h00;
      end else if (state_q == ADCC_CONV && !live) begin
         result_q <= result_q;
      end else if (state_q == ADCC_CONV && tick_q == 2'(ADCC_CLK_PER_BIT - 1)
                   && cmp_ok && bit_q == 3'h0) begin
         result_q <= {trial_q[7:1], cmp_s3};
      end
   end

   // ----------------------------------------
   // read data and outputs
   // ----------------------------------------
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h0;
      if (hit_res) begin
         rdata_d[7:0] = result_q;
      end else if (hit_ctl) begin
         // start and reserved read zero
         rdata_d[ADCC_BIT_IE] = ie_q;
         rdata_d[ADCC_BIT_DONE] = done_q;
         rdata_d[ADCC_BIT_PWR] = pwr_q;
         rdata_d[ADCC_BIT_OSC] = osc_q;
      end
   end
   assign PRDATA = rdata_d;
   assign IRQ = ie_q && done_q;
   assign WAKE = IRQ && WAIT_MODE && !STOP_MODE;
   assign MAIN_OSC_DISABLE = osc_q;
   assign CONV_POWER = live;
   assign DAC.trial = trial_q;
   assign DAC.sample = sample_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // step sequences shared by the properties below
   sequence s_start;
      start_wr && live;
   endsequence
   sequence s_finish;
      fin && !start_wr;
   endsequence
   sequence s_step;
      state_q == ADCC_CONV && live && !start_wr && tick_q == 2'(ADCC_CLK_PER_BIT - 1)
         && cmp_ok && bit_q != 3'h0;
   endsequence
   sequence s_running;
      state_q == ADCC_CONV && live && !start_wr;
   endsequence

   // done flag behaviour
   a_start_clears_done: assert property (@(posedge REF_CLK) disable iff (RST)
      start_wr |=> !done_q)
      else $error("start did not clear done");
   a_done_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
      done_q && !start_wr |=> done_q)
      else $error("done dropped without start");
   a_done_cause: assert property (@(posedge REF_CLK) disable iff (RST)
      $rose(done_q) |-> $past(fin))
      else $error("done set without completion");
   a_done_on_finish: assert property (@(posedge REF_CLK) disable iff (RST)
      s_finish |=> done_q)
      else $error("completion did not set done");
   // an abort must not leave a stale done behind
   a_done_held_off: assert property (@(posedge REF_CLK) disable iff (RST)
      !done_q && !live && !fin |=> !done_q)
      else $error("done set while converter off");

   // interrupt and wake
   a_irq_gate: assert property (@(posedge REF_CLK) disable iff (RST)
      IRQ == (ie_q && done_q))
      else $error("irq not gated by enable");
   a_irq_needs_enable: assert property (@(posedge REF_CLK) disable iff (RST)
      !ie_q |-> !IRQ)
      else $error("irq without enable");
   a_wake_in_wait: assert property (@(posedge REF_CLK) disable iff (RST)
      IRQ && WAIT_MODE && !STOP_MODE |-> WAKE)
      else $error("no wake from wait");
   a_no_stop_wake: assert property (@(posedge REF_CLK) disable iff (RST)
      STOP_MODE |-> !WAKE)
      else $error("wake raised in stop");

   // register access
   a_start_reads_zero: assert property (@(posedge REF_CLK) disable iff (RST)
      hit_ctl |-> !PRDATA[ADCC_BIT_START])
      else $error("start bit read as one");
   a_result_read: assert property (@(posedge REF_CLK) disable iff (RST)
      hit_res |-> PRDATA == 32'(result_q))
      else $error("result read wrong");
   a_result_ro: assert property (@(posedge REF_CLK) disable iff (RST)
      acc && PWRITE && hit_res |-> PSLVERR)
      else $error("result write accepted");
   a_ctrl_no_error: assert property (@(posedge REF_CLK) disable iff (RST)
      acc && hit_ctl |-> !PSLVERR)
      else $error("control access refused");
   a_ie_write: assert property (@(posedge REF_CLK) disable iff (RST)
      wr && hit_ctl |=> ie_q == $past(PWDATA[ADCC_BIT_IE]))
      else $error("enable bit not written");
   a_pwr_write: assert property (@(posedge REF_CLK) disable iff (RST)
      wr && hit_ctl |=> pwr_q == $past(PWDATA[ADCC_BIT_PWR]))
      else $error("power bit not written");
   // oscillator bit only leaves the block, the sequencer never reads it
   a_osc_write: assert property (@(posedge REF_CLK) disable iff (RST)
      wr && hit_ctl |=> MAIN_OSC_DISABLE == $past(PWDATA[ADCC_BIT_OSC]))
      else $error("oscillator bit not routed");
   a_ctrl_reset: assert property (@(posedge REF_CLK)
      RST |=> {ie_q, done_q, pwr_q, osc_q} == 4'b0100)
      else $error("control reset value wrong");

   // sequencer
   a_restart_msb: assert property (@(posedge REF_CLK) disable iff (RST)
      s_start |=> state_q == ADCC_CONV && trial_q == 8'h80 && bit_q == 3'h7)
      else $error("restart not from msb");
   a_bit_step: assert property (@(posedge REF_CLK) disable iff (RST)
      s_step |=> bit_q == $past(bit_q) - 3'h1)
      else $error("bit order not msb first");
   // result only moves on the last decision, so it stands while done is high
   a_result_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      state_q != ADCC_CONV |=> $stable(result_q))
      else $error("result changed outside conversion");
   a_wait_keeps: assert property (@(posedge REF_CLK) disable iff (RST)
      s_running |=> state_q inside {ADCC_CONV, ADCC_LOAD})
      else $error("conversion interrupted");
   a_one_shot: assert property (@(posedge REF_CLK) disable iff (RST)
      state_q == ADCC_IDLE && !start_wr |=> state_q == ADCC_IDLE)
      else $error("conversion without start");
   a_load_to_idle: assert property (@(posedge REF_CLK) disable iff (RST)
      s_finish |=> state_q == ADCC_IDLE)
      else $error("converter kept running");
   a_sample_idle: assert property (@(posedge REF_CLK) disable iff (RST)
      state_q == ADCC_IDLE |-> !DAC.sample)
      else $error("sampling while idle");
   a_stop_idle: assert property (@(posedge REF_CLK) disable iff (RST)
      STOP_MODE ##1 STOP_MODE |-> state_q == ADCC_IDLE && !WAKE)
      else $error("converter active in stop");
   a_stop_abort: assert property (@(posedge REF_CLK) disable iff (RST)
      STOP_MODE |=> state_q == ADCC_IDLE)
      else $error("stop did not abort");
   a_power_gate: assert property (@(posedge REF_CLK) disable iff (RST)
      !pwr_q |-> !CONV_POWER)
      else $error("converter powered while off");
   a_power_off: assert property (@(posedge REF_CLK) disable iff (RST)
      !pwr_q |=> state_q == ADCC_IDLE || $past(start_wr))
      else $error("converter ran while off");
endmodule

/* File: test/adcc_analog_model.sv */
// analog source and comparator standing in front of the converter
`timescale 1ns/1ps
module adcc_analog_model import adcc_pkg::*; (
   // sequencer side
   input wire adcc_dac_s dac,
   input wire logic [7:0] vin,
   // comparator answer
   output logic cmp_high
);
   // ideal comparator, so the code found equals the input level
   assign cmp_high = (vin >= dac.trial);
endmodule

/* File: test/adcc_top_bench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_bench import adcc_pkg::*;;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wt = 0, st = 0, cmp;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic pready, pslverr, irq, wake, pwr, osc, e;
   logic [7:0] vin = 0;
   adcc_dac_s dac;
   int num_errors = 0, samples_checked = 0, cyc = 0, v;
   adcc_top i_adcc_top (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .WAIT_MODE(wt), .STOP_MODE(st), .CMP_HIGH(cmp), .DAC(dac),
      .CONV_POWER(pwr), .IRQ(irq), .WAKE(wake), .MAIN_OSC_DISABLE(osc));
   adcc_analog_model i_adcc_analog_model (.dac(dac), .vin(vin), .cmp_high(cmp));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial forever #25 clk = ~clk;
   // hang guard, well past the longest scenario
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         stop_test();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is seen
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // start with enable and power, then wait for the done level
   task conv(input logic [7:0] a, input logic [7:0] b);
      vin <= a;
      apb(1, ADCC_CTRL_ADDR, 32'h0000_00b0);
      apb(0, ADCC_CTRL_ADDR, 0);
      check(r, 32'h0000_0090);
      check(irq, 0);
      repeat (9) @(posedge clk);
      vin <= b;
      if (a != b) apb(1, ADCC_CTRL_ADDR, 32'h0000_00b0);
      for (int i = 0; i < 900 && irq !== 1'b1; i++) @(posedge clk);
      #1 check(irq, 1);
      check(wake, wt);
      apb(0, ADCC_RESULT_ADDR, 0);
      check(r, {24'h0, b});
      apb(0, ADCC_CTRL_ADDR, 0);
      check(r, 32'h0000_00d0);
      apb(1, ADCC_CTRL_ADDR, 32'h0000_0010);
      #1 check(irq, 0);
   endtask
   task stop_test();
      if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      v = $urandom(64);
      repeat (12) @(posedge clk);
      rst <= 0;
      apb(0, ADCC_CTRL_ADDR, 0);
      check(r, {24'h0, ADCC_CTRL_RESET});
      check(irq, 0);
      apb(0, 32'h0000_00d4, 0);
      check({r, 31'h0, e}, 64'h1);
      apb(1, ADCC_RESULT_ADDR, 32'h0000_00ff);
      check(e, 1);
      // enable, power and oscillator bits written, done kept by a zero write
      apb(1, ADCC_CTRL_ADDR, 32'h0000_0094);
      apb(0, ADCC_CTRL_ADDR, 0);
      check(r, 32'h0000_00d4);
      check({osc, irq, pwr}, 3'b111);
      wt <= 1;
      @(posedge clk);
      #1 check(wake, 1);
      @(posedge clk);
      st <= 1;
      @(posedge clk);
      #1 check({wake, pwr}, 0);
      @(posedge clk);
      st <= 0;
      conv(8'hff, 8'hff);
      wt <= 0;
      conv(8'h00, 8'h00);
      repeat (3) conv($urandom, $urandom);
      // power off aborts, done must stay low
      apb(1, ADCC_CTRL_ADDR, 32'h0000_00b0);
      apb(1, ADCC_CTRL_ADDR, 32'h0000_0080);
      repeat (200) @(posedge clk);
      apb(0, ADCC_CTRL_ADDR, 0);
      check({r, pwr, irq}, 34'h200);
      stop_test();
   end
endmodule
